/* hw/ies_pkg.sv */
// Constants, types and helpers shared by the interrupt enable set bank
package ies_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int IES_ADDR_W = 12;
    localparam int IES_DATA_W = 32;
    localparam int IES_STRB_W = 4;

    // ----------------------------------------------------------------
    // Register map and field layout
    // ----------------------------------------------------------------
    localparam logic [11:0] IES_BANK_OFFSET = 12'h000;
    // Bits 27:26, 23:8 and 3:0 carry an enable; the rest are absent
    localparam logic [31:0] IES_IMPL_MASK = 32'h0cffff0f;
    localparam logic [31:0] IES_BANK_RESET = 32'h00000000;
    // Bank bit 0 stands for this interrupt number, bit 31 for the top
    localparam int IES_IRQ_LO = 32;
    localparam int IES_IRQ_HI = 63;

    // ----------------------------------------------------------------
    // Bus answers
    // ----------------------------------------------------------------
    localparam logic [1:0] IES_RESP_OKAY = 2'h0;
    localparam logic [1:0] IES_RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } ies_wr_req_t;

    typedef enum {IES_WR_COLLECT, IES_WR_RESP} ies_wr_state_t;
    typedef enum {IES_RD_IDLE, IES_RD_RESP} ies_rd_state_t;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic ies_hits_bank(input logic [11:0] addr);
        return addr[11:2] == IES_BANK_OFFSET[11:2];
    endfunction : ies_hits_bank

    function automatic logic [31:0] ies_lane_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : ies_lane_mask

endpackage : ies_pkg

/* hw/ies_set_bank.sv */
// Write-one-to-set enable bank for interrupts 32 to 63
`timescale 1ns/1ps
module ies_set_bank (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_write,
    input wire logic [ies_pkg::IES_DATA_W-1:0] i_wdata,
    input wire logic [ies_pkg::IES_STRB_W-1:0] i_wstrb,
    output logic [ies_pkg::IES_DATA_W-1:0] o_enable
);
    import ies_pkg::*;

    logic [31:0] enable_reg;
    logic [31:0] set_mask;

    // ----------------------------------------------------------------
    // Set logic
    // ----------------------------------------------------------------
    // Ones set, zeros keep; only reset clears an enable here
    assign set_mask = i_wdata & ies_lane_mask(i_wstrb) & IES_IMPL_MASK;

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            enable_reg <= IES_BANK_RESET;
        end else if (i_write) begin
            enable_reg <= enable_reg | set_mask;
        end
    end

    assign o_enable = enable_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_ONE_SETS: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        i_write |=> ((o_enable & $past(set_mask)) == $past(set_mask)))
        else $error("Written one did not set its enable");

    AST_ZERO_KEEPS: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        ##1 (($past(o_enable) & ~o_enable) == 32'h00000000))
        else $error("An enable was cleared through the set bank");

    AST_ABSENT_ZERO: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        (o_enable & ~IES_IMPL_MASK) == 32'h00000000)
        else $error("Unimplemented enable bit became set");

endmodule : ies_set_bank

/* hw/ies_top.sv */
// AXI4-Lite slave for the second interrupt enable set bank
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module ies_top (
    input wire logic i_clock,
    input wire logic i_reset_n,
    // Write address channel
    input wire logic i_awvalid,
    input wire logic [ies_pkg::IES_ADDR_W-1:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    output logic o_awready,
    // Write data channel
    input wire logic i_wvalid,
    input wire logic [ies_pkg::IES_DATA_W-1:0] i_wdata,
    input wire logic [ies_pkg::IES_STRB_W-1:0] i_wstrb,
    output logic o_wready,
    // Write response channel
    output logic o_bvalid,
    output logic [1:0] o_bresp,
    input wire logic i_bready,
    // Read address channel
    input wire logic i_arvalid,
    input wire logic [ies_pkg::IES_ADDR_W-1:0] i_araddr,
    input wire logic [2:0] i_arprot,
    output logic o_arready,
    // Read data channel
    output logic o_rvalid,
    output logic [ies_pkg::IES_DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_rready,
    // Enables toward the rest of the controller, one per interrupt
    output logic [ies_pkg::IES_IRQ_HI:ies_pkg::IES_IRQ_LO]
        o_interrupt_enable_set_bit
);
    import ies_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ies_wr_state_t wr_state_reg;
    ies_rd_state_t rd_state_reg;
    ies_wr_req_t wr_req;
    logic wr_both_held;
    logic wr_take;
    logic bank_write;
    logic [31:0] enable;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic ar_fire;
    logic prot_unused;

    // Protection bits carry no meaning for this bank
    assign prot_unused = ^{i_awprot, i_arprot};

    // ----------------------------------------------------------------
    // Write capture
    // ----------------------------------------------------------------
    ies_wr_capture u_wr_capture (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_awvalid(i_awvalid),
        .i_awaddr(i_awaddr),
        .o_awready(o_awready),
        .i_wvalid(i_wvalid),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .o_wready(o_wready),
        .i_take(wr_take),
        .o_both_held(wr_both_held),
        .o_req(wr_req)
    );

    // ----------------------------------------------------------------
    // Write response
    // ----------------------------------------------------------------
    // A held pair is taken only while no response is waiting, so a
    // stalled bready back-pressures both write channels
    assign wr_take = (wr_state_reg == IES_WR_COLLECT) && wr_both_held;
    assign bank_write = wr_take && ies_hits_bank(wr_req.addr);

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_state_reg <= IES_WR_COLLECT;
            bvalid_reg <= 1'b0;
            bresp_reg <= IES_RESP_OKAY;
        end else begin
            case (wr_state_reg)
                IES_WR_COLLECT: begin
                    if (wr_both_held) begin
                        wr_state_reg <= IES_WR_RESP;
                        bvalid_reg <= 1'b1;
                        bresp_reg <= ies_hits_bank(wr_req.addr) ?
                            IES_RESP_OKAY : IES_RESP_SLVERR;
                    end
                end
                IES_WR_RESP: begin
                    if (i_bready) begin
                        wr_state_reg <= IES_WR_COLLECT;
                        bvalid_reg <= 1'b0;
                    end
                end
                default: begin
                    wr_state_reg <= IES_WR_COLLECT;
                    bvalid_reg <= 1'b0;
                end
            endcase
        end
    end

    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;

    // ----------------------------------------------------------------
    // Enable bank
    // ----------------------------------------------------------------
    ies_set_bank u_set_bank (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write(bank_write),
        .i_wdata(wr_req.data),
        .i_wstrb(wr_req.strb),
        .o_enable(enable)
    );

    // Bank bit n drives interrupt number n plus the low base
    assign o_interrupt_enable_set_bit = enable;

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    assign ar_fire = i_arvalid && arready_reg;

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_state_reg <= IES_RD_IDLE;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= IES_RESP_OKAY;
        end else begin
            case (rd_state_reg)
                IES_RD_IDLE: begin
                    if (ar_fire) begin
                        rd_state_reg <= IES_RD_RESP;
                        arready_reg <= 1'b0;
                        rvalid_reg <= 1'b1;
                        if (ies_hits_bank(i_araddr)) begin
                            // Absent bits are already zero in the bank
                            rdata_reg <= enable;
                            rresp_reg <= IES_RESP_OKAY;
                        end else begin
                            rdata_reg <= 32'h00000000;
                            rresp_reg <= IES_RESP_SLVERR;
                        end
                    end
                end
                IES_RD_RESP: begin
                    if (i_rready) begin
                        rd_state_reg <= IES_RD_IDLE;
                        arready_reg <= 1'b1;
                        rvalid_reg <= 1'b0;
                    end
                end
                default: begin
                    rd_state_reg <= IES_RD_IDLE;
                    arready_reg <= 1'b1;
                    rvalid_reg <= 1'b0;
                end
            endcase
        end
    end

    assign o_arready = arready_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_bank_read;
        ar_fire && ies_hits_bank(i_araddr);
    endsequence

    sequence s_read_answer;
        o_rvalid && (o_rresp == IES_RESP_OKAY);
    endsequence

    sequence s_set_hi;
        bank_write && wr_req.data[27] && wr_req.strb[3];
    endsequence

    sequence s_set_lo;
        bank_write && wr_req.data[0] && wr_req.strb[0];
    endsequence

    sequence s_zero_write;
        bank_write
            && ((wr_req.data & ies_lane_mask(wr_req.strb)) == 32'h00000000);
    endsequence

    // Two low samples in a row, so the flops have seen reset at least once
    sequence s_reset_held;
        !i_reset_n ##1 !i_reset_n;
    endsequence

    AST_READ_STATE: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        s_bank_read |=> s_read_answer
            ##0 (o_rdata == $past(enable)))
        else $error("Read did not return the enable state");

    AST_READ_ABSENT_ZERO: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        o_rvalid |-> ((o_rdata & ~IES_IMPL_MASK) == 32'h00000000))
        else $error("Read showed a set unimplemented bit");

    AST_READ_MAP_HI: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        s_bank_read |=> (o_rdata[27:26]
            == $past(o_interrupt_enable_set_bit[59:58])))
        else $error("Read bits 27:26 differ from interrupts 59:58");

    AST_READ_MAP_LO: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        s_bank_read |=> (o_rdata[3:0]
            == $past(o_interrupt_enable_set_bit[35:32])))
        else $error("Read bits 3:0 differ from interrupts 35:32");

    AST_HI_MAP: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        s_set_hi |=> o_interrupt_enable_set_bit[59])
        else $error("Bit 27 did not enable interrupt 59");

    AST_HI_MAP_26: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        bank_write && wr_req.data[26] && wr_req.strb[3]
            |=> o_interrupt_enable_set_bit[58])
        else $error("Bit 26 did not enable interrupt 58");

    AST_LO_MAP: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        s_set_lo |=> o_interrupt_enable_set_bit[32])
        else $error("Bit 0 did not enable interrupt 32");

    AST_LO_MAP_3: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        bank_write && wr_req.data[3] && wr_req.strb[0]
            |=> o_interrupt_enable_set_bit[35])
        else $error("Bit 3 did not enable interrupt 35");

    AST_MID_MAP: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        bank_write && wr_req.data[8] && wr_req.strb[1]
            |=> o_interrupt_enable_set_bit[40])
        else $error("Bit 8 did not enable interrupt 40");

    AST_SINGLE_BIT: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        bank_write && (wr_req.data == 32'h00000001) && wr_req.strb[0]
            |=> (o_interrupt_enable_set_bit
            == ($past(o_interrupt_enable_set_bit) | 32'h00000001)))
        else $error("Bit 0 touched more than interrupt 32");

    AST_ZERO_WRITE_KEEPS: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        s_zero_write |=> $stable(o_interrupt_enable_set_bit))
        else $error("A write of zeros changed an enable");

    AST_STRAY_WRITE_KEEPS: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        wr_take && !ies_hits_bank(wr_req.addr)
            |=> $stable(o_interrupt_enable_set_bit)
            ##0 o_bvalid && (o_bresp == IES_RESP_SLVERR))
        else $error("Unmapped write disturbed the enables");

    AST_RESET_CLEARS: assert property (@(posedge i_clock)
        s_reset_held |-> (o_interrupt_enable_set_bit == 32'h00000000)
            && !o_bvalid && !o_rvalid)
        else $error("Reset left an enable or an answer standing");

    AST_WRITE_ANSWER: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        wr_take |=> o_bvalid ##0 (o_awready && o_wready))
        else $error("Write taken without a response");

    AST_BVALID_HOLDS: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("Write answer dropped before it was taken");

    AST_RVALID_HOLDS: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("Read data dropped before it was taken");

    AST_READ_REFUSED: assert property (@(posedge i_clock)
        disable iff (!i_reset_n)
        !o_arready |-> o_rvalid)
        else $error("Read address refused with no answer waiting");

endmodule : ies_top

/* hw/ies_wr_capture.sv */
// Write address and write data capture, taken in either order
`timescale 1ns/1ps
module ies_wr_capture (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_awvalid,
    input wire logic [ies_pkg::IES_ADDR_W-1:0] i_awaddr,
    output logic o_awready,
    input wire logic i_wvalid,
    input wire logic [ies_pkg::IES_DATA_W-1:0] i_wdata,
    input wire logic [ies_pkg::IES_STRB_W-1:0] i_wstrb,
    output logic o_wready,
    input wire logic i_take,
    output logic o_both_held,
    output ies_pkg::ies_wr_req_t o_req
);
    import ies_pkg::*;

    logic awready_reg;
    logic wready_reg;
    logic [11:0] addr_reg;
    logic [31:0] data_reg;
    logic [3:0] strb_reg;

    // ----------------------------------------------------------------
    // Address channel: ready drops while an address is held
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            awready_reg <= 1'b1;
            addr_reg <= 12'h000;
        end else if (i_awvalid && awready_reg) begin
            awready_reg <= 1'b0;
            addr_reg <= i_awaddr;
        end else if (i_take) begin
            awready_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Data channel
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wready_reg <= 1'b1;
            data_reg <= 32'h00000000;
            strb_reg <= 4'h0;
        end else if (i_wvalid && wready_reg) begin
            wready_reg <= 1'b0;
            data_reg <= i_wdata;
            strb_reg <= i_wstrb;
        end else if (i_take) begin
            wready_reg <= 1'b1;
        end
    end

    assign o_awready = awready_reg;
    assign o_wready = wready_reg;
    assign o_both_held = !awready_reg && !wready_reg;
    assign o_req = '{addr: addr_reg, data: data_reg, strb: strb_reg};

endmodule : ies_wr_capture

/* tb/ies_testbench.sv */
// Self-checking bench for the second interrupt enable set bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    err_total++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module testbench;
    import ies_pkg::*;

    // ----------------------------------------------------------------
    // Signals and design
    // ----------------------------------------------------------------
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_awvalid = 1'b0;
    logic [11:0] i_awaddr = 12'h000;
    logic [2:0] i_awprot = 3'h0;
    logic i_wvalid = 1'b0;
    logic [31:0] i_wdata = 32'h00000000;
    logic [3:0] i_wstrb = 4'h0;
    logic i_bready = 1'b0;
    logic i_arvalid = 1'b0;
    logic [11:0] i_araddr = 12'h000;
    logic [2:0] i_arprot = 3'h0;
    logic i_rready = 1'b0;
    logic o_awready;
    logic o_wready;
    logic o_bvalid;
    logic [1:0] o_bresp;
    logic o_arready;
    logic o_rvalid;
    logic [31:0] o_rdata;
    logic [1:0] o_rresp;
    logic [63:32] o_interrupt_enable_set_bit;
    int err_total = 0;
    int cmp_count = 0;

    always #5 i_clock = ~i_clock;

    ies_top i_ies_top (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_awvalid(i_awvalid),
        .i_awaddr(i_awaddr),
        .i_awprot(i_awprot),
        .o_awready(o_awready),
        .i_wvalid(i_wvalid),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .o_wready(o_wready),
        .o_bvalid(o_bvalid),
        .o_bresp(o_bresp),
        .i_bready(i_bready),
        .i_arvalid(i_arvalid),
        .i_araddr(i_araddr),
        .i_arprot(i_arprot),
        .o_arready(o_arready),
        .o_rvalid(o_rvalid),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .i_rready(i_rready),
        .o_interrupt_enable_set_bit(o_interrupt_enable_set_bit)
    );

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    // Each task waits one edge first, so two calls in a row never drive
    // the same signal twice in one time step
    // A nonzero bdly or rdly holds off the answer's ready to force stalls
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, input int wdly, output logic [1:0] r,
            input int bdly = 0);
        int n;
        n = 0;
        r = 2'h3;
        @(posedge i_clock);
        i_awvalid <= 1'b1;
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= s;
        i_bready <= (bdly == 0);
        if (wdly == 0) i_wvalid <= 1'b1;
        while (n < 40) begin
            @(posedge i_clock);
            n++;
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            else if (!i_wvalid && n == wdly) i_wvalid <= 1'b1;
            if (o_bvalid && i_bready) begin
                r = o_bresp;
                i_bready <= 1'b0;
                n = 99;
            end else if (!i_bready && n == bdly) begin
                i_bready <= 1'b1;
            end
        end
        if (n != 99) begin
            err_total++;
            $display("[ERR] write answer expected 1 seen 0");
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
            output logic [1:0] r, input int rdly = 0);
        int n;
        n = 0;
        d = 32'hffffffff;
        r = 2'h3;
        @(posedge i_clock);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= (rdly == 0);
        while (n < 40) begin
            @(posedge i_clock);
            n++;
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (o_rvalid && i_rready) begin
                d = o_rdata;
                r = o_rresp;
                i_rready <= 1'b0;
                n = 99;
            end else if (!i_rready && n == rdly) begin
                i_rready <= 1'b1;
            end
        end
        if (n != 99) begin
            err_total++;
            $display("[ERR] read answer expected 1 seen 0");
        end
    endtask : axi_rd

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Ordinary cases: write, then read back; state accumulates
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
        logic [1:0] bresp;
        logic [31:0] rdata;
    } ies_tb_row_t;

    ies_tb_row_t rows [9] = '{
        '{12'h000, 32'h00000001, 4'hf, 2'h0, 32'h00000001},
        '{12'h000, 32'h0000000e, 4'hf, 2'h0, 32'h0000000f},
        '{12'h000, 32'h00000000, 4'hf, 2'h0, 32'h0000000f},
        '{12'h000, 32'h04000000, 4'hf, 2'h0, 32'h0400000f},
        '{12'h000, 32'hf0ff00f0, 4'hf, 2'h0, 32'h04ff000f},
        '{12'h000, 32'h0800ff00, 4'h2, 2'h0, 32'h04ffff0f},
        '{12'h000, 32'h08000000, 4'h0, 2'h0, 32'h04ffff0f},
        '{12'h004, 32'h08000000, 4'hf, 2'h2, 32'h04ffff0f},
        '{12'h000, 32'h08000000, 4'h8, 2'h0, 32'h0cffff0f}
    };

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic [1:0] resp;
        logic [1:0] wresp;
        repeat (8) @(posedge i_clock);
        i_reset_n <= 1'b1;
        `CHK("reset enables", 32'h0, o_interrupt_enable_set_bit)
        `CHK("readies", 3'h7, {o_awready, o_wready, o_arready})
        `CHK("answers", 2'h0, {o_bvalid, o_rvalid})
        axi_rd(12'h000, rd, resp);
        `CHK("bank at reset", IES_BANK_RESET, rd)
        for (int k = 0; k < 9; k++) begin
            axi_wr(rows[k].addr, rows[k].data, rows[k].strb, 0, resp);
            `CHK("bresp", rows[k].bresp, resp)
            axi_rd(12'h000, rd, resp);
            `CHK("rresp", IES_RESP_OKAY, resp)
            `CHK("rdata", rows[k].rdata, rd)
            `CHK("enables", rows[k].rdata, o_interrupt_enable_set_bit)
        end
        // Unmapped read gives an error and no data
        axi_rd(12'h008, rd, resp);
        `CHK("unmapped rresp", IES_RESP_SLVERR, resp)
        `CHK("unmapped rdata", 32'h00000000, rd)
        // Reset in mid-run clears every enable at once
        @(posedge i_clock);
        i_reset_n <= 1'b0;
        #2;
        `CHK("mid enables", 32'h0, o_interrupt_enable_set_bit)
        `CHK("mid readies", 3'h7, {o_awready, o_wready, o_arready})
        repeat (2) @(posedge i_clock);
        i_reset_n <= 1'b1;
        // Read taken with a write sees the value before the write
        fork
            axi_wr(12'h000, 32'h00000002, 4'hf, 0, wresp);
            axi_rd(12'h000, rd, resp);
        join
        `CHK("read beside write", 32'h00000000, rd)
        axi_rd(12'h000, rd, resp);
        `CHK("after write", 32'h00000002, rd)
        // Data arrives three cycles after the address
        axi_wr(12'h000, 32'h00800000, 4'hf, 3, wresp);
        `CHK("late data bresp", IES_RESP_OKAY, wresp)
        axi_rd(12'h000, rd, resp);
        `CHK("late data", 32'h00800002, rd)
        `CHK("late enables", 32'h00800002, o_interrupt_enable_set_bit)
        // Master holds off bready and rready; answers must wait unchanged
        axi_wr(12'h000, 32'h08000000, 4'h8, 0, wresp, 4);
        `CHK("stalled bresp", IES_RESP_OKAY, wresp)
        axi_rd(12'h000, rd, resp, 3);
        `CHK("stalled rresp", IES_RESP_OKAY, resp)
        `CHK("stalled rdata", 32'h08800002, rd)
        close_out();
    end

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    // The whole sequence needs about a hundred cycles; this is ample
    initial begin
        repeat (3000) @(posedge i_clock);
        err_total++;
        close_out();
    end

endmodule : testbench
